/* File: core/conv_device.sv */
// Functional notes
// - Result is two's complement, sign first
// - Round to nearest, clamp -4096 to 4095
// - Acquisition of 6, 10, 18, 34 periods
// - Acquire from falling sclk to conversion_clock
// - Sync may add one conversion period
// - Calibration stores corrections, used afterwards
// - Host calibrates only after supplies settle
// - Zeroing command corrects only offset
// - Reset defaults: 10 periods, sign, 13 bits
// - Cal, zero, power commands keep configuration
// - All-zero instruction: 12- or 13-bit conversion, long format off
// - Host clocks exact output word length
// - Host shifts instruction, first bit first
// - Output word 12, 13, 16, 17 bits
// - Host should calibrate first after power-up
`timescale 1ns/1ps
`default_nettype none
module conv_device
    import conv_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Serial link
    conv_link_if.converter                   link,
    // Analog sample stand-in: scaled input times 2
    input  wire logic signed [RESULT_W+1:0]  sample_x2,
    input  wire logic signed [RESULT_W-1:0]  offset_meas,
    input  wire logic signed [RESULT_W-1:0]  gain_meas,
    // Status
    output logic                             busy,
    output logic                             calibrated,
    output logic                             powered_down,
    output logic [5:0]                       last_acq_periods
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ACQ  = 5'b00010,
        S_CONV = 5'b00100,
        S_CAL  = 5'b01000,
        S_ZERO = 5'b10000
    } dev_state_t;

    logic [2:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] din_sync_reg;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_active;
    assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
    assign cs_active = !cs_sync_reg[1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_sync_reg <= '0;
            cs_sync_reg   <= 2'h3;
            din_sync_reg  <= '0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
            cs_sync_reg   <= {cs_sync_reg[0], link.cs_n};
            din_sync_reg  <= {din_sync_reg[0], link.serial_instruction_in};
        end
    end

    // Conversion clock as enable pulse
    logic [$clog2(CONVERSION_CLOCK_DIV)-1:0] cdiv_reg;
    logic                        conversion_clock_en;
    assign conversion_clock_en = cdiv_reg == '0;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cdiv_reg <= '0;
        end else begin
            cdiv_reg <= cdiv_reg + 1'b1;
        end
    end

    // Configuration
    logic [1:0] acq_code_reg;
    logic       sign_on_reg;
    logic       long_reg;
    logic       pd_reg;
    logic [4:0] wlen;
    assign wlen = word_len(sign_on_reg, long_reg);

    // Transfer
    instr_t     instr_reg;
    logic [4:0] bit_cnt_reg;
    logic [16:0] shift_reg;
    logic       dout_reg;
    logic       frame_done;
    logic       was_cs_reg;
    assign frame_done = was_cs_reg && !cs_active;

    dev_state_t  state_reg;
    logic [5:0]  cnt_reg;
    logic [5:0]  acq_seen_reg;
    logic        acq_armed_reg;
    logic signed [RESULT_W-1:0] offset_corr_reg;
    logic signed [RESULT_W-1:0] gain_corr_reg;
    logic        cal_done_reg;

    // Result FIFO holds finished words until the next frame loads one
    logic                       res_in_valid;
    logic                       res_in_ready;
    logic signed [RESULT_W-1:0] res_in_data;
    logic                       res_out_valid;
    logic                       res_out_ready;
    logic [RESULT_W-1:0]        res_out_data;

    sync_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_res_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (res_in_valid),
        .in_ready  (res_in_ready),
        .in_data   (res_in_data),
        .out_valid (res_out_valid),
        .out_ready (res_out_ready),
        .out_data  (res_out_data)
    );

    // Rounding: sample_x2 carries one fraction bit
    function automatic logic signed [RESULT_W-1:0] round_clamp(
        input logic signed [RESULT_W+1:0] x2);
        logic signed [RESULT_W+1:0] r;
        r = (x2 + 15'sd1) >>> 1;
        if (r > 15'(CODE_MAX)) begin
            round_clamp = CODE_MAX;
        end else if (r < 15'(signed'(CODE_MIN))) begin
            round_clamp = CODE_MIN;
        end else begin
            round_clamp = r[RESULT_W-1:0];
        end
    endfunction

    logic signed [RESULT_W+1:0] corrected;
    assign corrected = sample_x2 - {offset_corr_reg[RESULT_W-1], offset_corr_reg, 1'b0}
                     + {gain_corr_reg[RESULT_W-1], gain_corr_reg, 1'b0};
    assign res_in_data   = round_clamp(corrected);
    assign res_in_valid  = state_reg == S_CONV && conversion_clock_en && cnt_reg == 6'd1;
    assign res_out_ready = cs_active && !was_cs_reg && res_out_valid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            was_cs_reg  <= 1'b0;
            bit_cnt_reg <= '0;
            instr_reg   <= '0;
            shift_reg   <= '0;
            dout_reg    <= 1'b0;
        end else begin
            was_cs_reg <= cs_active;
            if (cs_active && !was_cs_reg) begin
                bit_cnt_reg <= '0;
                // Left-align so the sign, or bit 11 with sign off, leaves first; pad bits follow
                shift_reg <= sign_on_reg ? {res_out_data, 4'h0}
                                         : {res_out_data[RESULT_W-2:0], 5'h00};
                dout_reg  <= sign_on_reg ? res_out_data[RESULT_W-1]
                                         : res_out_data[RESULT_W-2];
            end else if (cs_active && sclk_rise && bit_cnt_reg < wlen) begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
                if (bit_cnt_reg < 5'(INSTR_BITS)) begin
                    instr_reg[bit_cnt_reg[2:0]] <= din_sync_reg[1];
                end
            end else if (cs_active && sclk_fall) begin
                shift_reg <= {shift_reg[15:0], 1'b0};
                dout_reg  <= shift_reg[15];
            end
        end
    end

    // Configuration changes on its own commands; convert also clears long_reg
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acq_code_reg <= ACQ_RESET;
            sign_on_reg  <= SIGN_ON_RESET;
            long_reg     <= LONG_RESET;
            pd_reg       <= 1'b0;
        end else if (frame_done && bit_cnt_reg == wlen) begin
            case (instr_reg[INSTR_CMD_W-1:0])
                CMD_ACQ:       acq_code_reg <= instr_reg[5:4];
                CMD_FORMAT: begin
                    sign_on_reg <= !instr_reg[4];
                    long_reg    <= instr_reg[5];
                end
                CMD_CONVERT:   long_reg <= 1'b0;
                CMD_POWERDOWN: pd_reg <= 1'b1;
                CMD_POWERUP:   pd_reg <= 1'b0;
                default:       pd_reg <= pd_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg       <= S_IDLE;
            cnt_reg         <= '0;
            acq_seen_reg    <= '0;
            acq_armed_reg   <= 1'b0;
            offset_corr_reg <= '0;
            gain_corr_reg   <= '0;
            cal_done_reg    <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    // Window opens on the last falling sclk of a convert frame
                    if (cs_active && sclk_fall && bit_cnt_reg == wlen && !pd_reg
                        && instr_reg[3:0] == CMD_CONVERT) begin
                        acq_armed_reg <= 1'b1;
                    end
                    if (acq_armed_reg && conversion_clock_en) begin
                        // First conversion_clock edge after the window opened is the sync period
                        state_reg     <= S_ACQ;
                        cnt_reg       <= acq_periods(acq_code_reg);
                        acq_seen_reg  <= 6'd1;
                        acq_armed_reg <= 1'b0;
                    end else if (frame_done && instr_reg[3:0] == CMD_CALIBRATE) begin
                        state_reg <= S_CAL;
                        cnt_reg   <= 6'(CAL_PERIODS - 1);
                    end else if (frame_done && instr_reg[3:0] == CMD_ZERO) begin
                        state_reg <= S_ZERO;
                        cnt_reg   <= 6'(ZERO_PERIODS);
                    end
                end
                S_ACQ: if (conversion_clock_en) begin
                    acq_seen_reg <= acq_seen_reg + 1'b1;
                    if (cnt_reg == 6'd1) begin
                        state_reg <= S_CONV;
                        cnt_reg   <= 6'(CONV_PERIODS);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_CONV: if (conversion_clock_en) begin
                    if (cnt_reg == 6'd1) begin
                        state_reg <= S_IDLE;
                    end else if (res_in_ready || cnt_reg != 6'd2) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_CAL: if (conversion_clock_en) begin
                    if (cnt_reg == 6'd1) begin
                        offset_corr_reg <= offset_meas;
                        gain_corr_reg   <= gain_meas;
                        cal_done_reg    <= 1'b1;
                        state_reg       <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                S_ZERO: if (conversion_clock_en) begin
                    if (cnt_reg == 6'd1) begin
                        offset_corr_reg <= offset_meas;
                        state_reg       <= S_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy             <= 1'b0;
            calibrated       <= 1'b0;
            powered_down     <= 1'b0;
            last_acq_periods <= '0;
            link.dout        <= 1'b0;
        end else begin
            busy         <= state_reg != S_IDLE || acq_armed_reg;
            calibrated   <= cal_done_reg;
            powered_down <= pd_reg;
            link.dout    <= dout_reg;
            if (state_reg == S_ACQ && conversion_clock_en && cnt_reg == 6'd1) begin
                last_acq_periods <= acq_seen_reg;
            end
        end
    end
endmodule // conv_device
`default_nettype wire

/* File: inc/conv_pkg.sv */
package conv_pkg;

    // Instruction field layout, first bit on the wire is bit 0
    localparam int INSTR_BITS      = 8;
    localparam int INSTR_CMD_LSB   = 0;
    localparam int INSTR_CMD_W     = 4;
    localparam int INSTR_ARG_LSB   = 4;
    localparam int INSTR_ARG_W     = 4;

    // Command codes
    localparam logic [3:0] CMD_CONVERT   = 4'h0;
    localparam logic [3:0] CMD_CALIBRATE = 4'h1;
    localparam logic [3:0] CMD_ZERO      = 4'h2;
    localparam logic [3:0] CMD_POWERDOWN = 4'h3;
    localparam logic [3:0] CMD_POWERUP   = 4'h4;
    localparam logic [3:0] CMD_ACQ       = 4'h5;
    localparam logic [3:0] CMD_FORMAT    = 4'h6;

    // Acquisition codes and period counts
    localparam logic [1:0] ACQ_6      = 2'h0;
    localparam logic [1:0] ACQ_10     = 2'h1;
    localparam logic [1:0] ACQ_18     = 2'h2;
    localparam logic [1:0] ACQ_34     = 2'h3;
    localparam logic [1:0] ACQ_RESET  = ACQ_10;

    // Result coding
    localparam int          RESULT_W   = 13;
    localparam logic signed [RESULT_W-1:0] CODE_MIN = 13'sh1000;
    localparam logic signed [RESULT_W-1:0] CODE_MAX = 13'sh0FFF;
    localparam int          FULL_SCALE = 4096;

    // Output formats: bit0 = sign off, bit1 = 16/17 bit padded
    localparam logic       SIGN_ON_RESET = 1'b1;
    localparam logic       LONG_RESET    = 1'b0;

    // Link timing
    localparam int  CLK_NS          = 25;
    localparam int  SCLK_PERIOD_NS  = 200;
    localparam int  SCLK_HALF_CYC   = (SCLK_PERIOD_NS / CLK_NS) / 2;
    localparam int  CONVERSION_CLOCK_DIV        = 4;
    localparam int  CAL_PERIODS     = 64;
    localparam int  ZERO_PERIODS    = 16;
    localparam int  CONV_PERIODS    = 14;

    // Controller register map (APB byte addresses)
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;

    typedef logic [INSTR_BITS-1:0] instr_t;

    function automatic logic [5:0] acq_periods(input logic [1:0] code);
        case (code)
            ACQ_6:   acq_periods = 6'd6;
            ACQ_10:  acq_periods = 6'd10;
            ACQ_18:  acq_periods = 6'd18;
            default: acq_periods = 6'd34;
        endcase
    endfunction

    function automatic logic [4:0] word_len(input logic sign_on, input logic long_fmt);
        word_len = 5'd12 + {4'h0, sign_on} + (long_fmt ? 5'd4 : 5'd0);
    endfunction

endpackage

/* File: inc/conv_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
    logic sclk;
    logic cs_n;
    logic serial_instruction_in;
    logic dout;
    modport converter (input sclk, input cs_n, input serial_instruction_in, output dout);
    modport host (output sclk, output cs_n, output serial_instruction_in, input dout);
endinterface
`default_nettype wire

/* File: core/sync_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    // Zero when empty, so a frame with nothing queued shifts no unknowns
    assign out_data  = out_valid ? mem[rd_ptr_reg[AW-1:0]] : '0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule // sync_fifo
`default_nettype wire

/* File: core/conv_host.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_host
    import conv_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    conv_link_if.host        link
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b100
    } host_state_t;

    host_state_t state_reg;
    instr_t      instr_reg;
    logic [4:0]  len_reg;
    logic [4:0]  bit_reg;
    logic [3:0]  half_reg;
    logic [16:0] rx_reg;
    logic [1:0]  dout_sync_reg;
    logic        done_reg;
    logic        start;

    // Word length is software's job: it must match the device's format
    assign start = psel && penable && pwrite && paddr == REG_CMD && state_reg == H_IDLE;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dout_sync_reg <= '0;
        end else begin
            dout_sync_reg <= {dout_sync_reg[0], link.dout};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= H_IDLE;
            instr_reg <= '0;
            len_reg   <= 5'd13;
            bit_reg   <= '0;
            half_reg  <= '0;
            rx_reg    <= '0;
            done_reg  <= 1'b0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.serial_instruction_in <= 1'b0;
        end else begin
            case (state_reg)
                H_IDLE: if (start) begin
                    instr_reg <= pwdata[INSTR_BITS-1:0];
                    len_reg   <= pwdata[12:8];
                    bit_reg   <= '0;
                    half_reg  <= 4'(SCLK_HALF_CYC);
                    done_reg  <= 1'b0;
                    rx_reg    <= '0;
                    link.cs_n <= 1'b0;
                    link.serial_instruction_in <= pwdata[0];
                    state_reg <= H_LOW;
                end
                H_LOW: if (half_reg == 4'd1) begin
                    half_reg <= 4'(SCLK_HALF_CYC);
                    if (bit_reg == len_reg) begin
                        link.cs_n <= 1'b1;
                        done_reg  <= 1'b1;
                        state_reg <= H_IDLE;
                    end else begin
                        link.sclk <= 1'b1;
                        bit_reg   <= bit_reg + 1'b1;
                        state_reg <= H_HIGH;
                    end
                end else begin
                    half_reg <= half_reg - 1'b1;
                end
                H_HIGH: if (half_reg == 4'd1) begin
                    half_reg  <= 4'(SCLK_HALF_CYC);
                    link.sclk <= 1'b0;
                    // Sample before the fall: the answer lags the previous fall by six clocks
                    rx_reg    <= {rx_reg[15:0], dout_sync_reg[1]};
                    link.serial_instruction_in <=
                        bit_reg < 5'(INSTR_BITS) ? instr_reg[bit_reg[2:0]] : 1'b0;
                    state_reg <= H_LOW;
                end else begin
                    half_reg <= half_reg - 1'b1;
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CMD
                       && paddr != REG_STATUS && paddr != REG_RESULT;
            case (paddr)
                REG_STATUS: prdata <= {30'h0, done_reg, state_reg != H_IDLE};
                REG_RESULT: prdata <= {15'h0, rx_reg};
                default:    prdata <= '0;
            endcase
        end
    end
endmodule // conv_host
`default_nettype wire

/* File: sim/serial_adc_acquisition_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_adc_acquisition_control_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_instruction_in,
    input wire logic dout
);
    logic       sclk_reg;
    logic [4:0] rise_cnt_reg;
    always_ff @(posedge ref_clk) begin
        sclk_reg <= sclk;
    end
    // Rises per frame, kept until the frame closes
    always_ff @(posedge ref_clk) begin
        if (rst || cs_n) begin
            rise_cnt_reg <= 5'h00;
        end else if (sclk && !sclk_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    idle_low_a: assert property (cs_n |-> !sclk)
        else $error("sclk high outside frame");
    high_half_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high phase wrong");
    low_half_a: assert property ($fell(sclk) |-> (!sclk)[*4])
        else $error("sclk low phase short");
    instr_hold_a: assert property ($rose(sclk) |-> $stable(serial_instruction_in)[*4])
        else $error("instruction bit moved");
    dout_hold_a: assert property ($rose(sclk) |=> $stable(dout)[*3])
        else $error("result bit moved");
    word_len_a: assert property ($rose(cs_n) |-> rise_cnt_reg inside {12, 13, 16, 17})
        else $error("bad word length");
    frame_max_a: assert property (!cs_n |-> rise_cnt_reg <= 5'd17)
        else $error("frame too long");
    frame_end_a: assert property ($rose(cs_n) |-> !$past(sclk))
        else $error("frame closed with sclk high");
    frame_start_a: assert property ($fell(cs_n) |-> (!sclk)[*2])
        else $error("sclk high at frame start");
    cover property ($rose(cs_n) && rise_cnt_reg == 5'd12);
    cover property ($rose(cs_n) && rise_cnt_reg == 5'd13);
    cover property ($rose(cs_n) && rise_cnt_reg == 5'd17);
endmodule // serial_adc_acquisition_control_asserts
`default_nettype wire

/* File: sim/test_serial_adc_acquisition_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_acquisition_control;
    import conv_pkg::*;
    typedef struct {logic signed [14:0] x2; logic [1:0] acq; logic [5:0] per; logic [12:0] code;} row_t;
    // Codes 3000, -1 and both clamps, one row per acquisition code
    row_t rows [4] = '{'{15'sh1770, ACQ_6, 6'h06, 13'h0BB8}, '{-15'sh0002, ACQ_10, 6'h0A, 13'h1FFF},
                       '{15'sh2328, ACQ_18, 6'h12, 13'h0FFF}, '{-15'sh2710, ACQ_34, 6'h22, 13'h1000}};
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, busy, err, calibrated, powered_down;
    logic signed [12:0] offset_meas;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic signed [14:0] sample_x2;
    logic [5:0] last_acq_periods;
    logic [12:0] prev;
    int failures, checks_done;
    conv_link_if link();
    conv_host u_conv_host (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    conv_device #(.FIFO_DEPTH(8)) u_conv_device (.ref_clk(ref_clk), .rst(rst),
        .link(link.converter), .sample_x2(sample_x2), .offset_meas(offset_meas),
        .gain_meas(13'sh0000), .busy(busy), .calibrated(calibrated), .powered_down(powered_down),
        .last_acq_periods(last_acq_periods));
    serial_adc_acquisition_control_asserts u_serial_adc_acquisition_control_asserts (
        .ref_clk(ref_clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n),
        .serial_instruction_in(link.serial_instruction_in), .dout(link.dout));
    task summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Sync may add one conversion period
    task chk_acq(input logic [5:0] per);
        checks_done++;
        if (last_acq_periods !== per && last_acq_periods !== per + 6'h01) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, last_acq_periods, per);
        end
    endtask
    task hang;
        failures++;
        summarize();
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang();
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // One frame, then wait until the converter is idle, then fetch rx bits
    task frame(input logic [7:0] ins, input logic [4:0] len);
        int n;
        apb(1'b1, REG_CMD, {19'h0, len, ins});
        n = 0;
        while (link.cs_n !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        // Busy follows the close of the frame by a few clocks
        repeat (8) @(posedge ref_clk);
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 4000 || link.cs_n !== 1'b1) hang();
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rdata, 32'h00000002);
        apb(1'b0, REG_RESULT, 32'h0);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sample_x2 = '0;
        offset_meas = '0;
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        frame(8'h01, 5'd13);
        frame(8'h00, 5'd13);
        chk_acq(6'h0A);
        prev = 13'h0000;
        for (int i = 0; i < 4; i++) begin
            sample_x2 <= rows[i].x2;
            frame({2'b00, rows[i].acq, 4'h5}, 5'd13);
            chk(rdata, {19'h0, prev});
            frame(8'h00, 5'd13);
            chk_acq(rows[i].per);
            prev = rows[i].code;
        end
        // Twelve clocks where thirteen are due: ignored
        frame({2'b00, ACQ_6, 4'h5}, 5'd12);
        frame(8'h00, 5'd13);
        chk_acq(6'h22);
        sample_x2 <= '0;
        offset_meas <= 13'sh0010;
        for (int c = 1; c < 5; c++) begin
            frame({4'h0, c[3:0]}, 5'd13);
            chk({30'h0, powered_down, calibrated}, {30'h0, c == 3, 1'b1});
            frame(8'h00, 5'd13);
            chk_acq(6'h22);
        end
        // Offset of 16 stored by calibration and zeroing: a zero input reads -16
        frame(8'h26, 5'd13);
        chk(rdata, 32'h00001FF0);
        frame(8'h00, 5'd17);
        frame(8'h00, 5'd13);
        chk_acq(6'h22);
        chk(rdata, 32'h00001FF0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Reset in mid-run: configuration back to its defaults
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk({30'h0, powered_down, calibrated}, 32'h0);
        frame(8'h00, 5'd13);
        chk_acq(6'h0A);
        summarize();
    end
endmodule // test_serial_adc_acquisition_control
`default_nettype wire
